/* hdl/hsi_top.sv */
// Serial command interface: synchronous serial port and two-wire write slave
`timescale 1ns/100ps
`default_nettype none
module hsi_top #(
	parameter int         CHANNELS = 16,
	parameter int         DATA_W   = 14,
	parameter logic [3:0] CH_MASK  = 4'hF
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic                           ce,
	input  wire logic                           if_select_pin,
	input  wire logic                           chain_enable_pin,
	input  wire logic                           addr_strap_hi,
	input  wire logic                           addr_strap_lo,
	input  wire logic                           frame_strobe_n,
	input  wire logic                           spi_sclk,
	input  wire logic                           serial_in,
	output logic                                serial_out,
	input  wire logic                           scl_in,
	input  wire logic                           sda_in,
	output logic                                sda_out,
	output logic                                sda_oe_n,
	input  wire logic [hsi_pkg::PAY_W-1:0]      readback_data,
	output logic [hsi_pkg::CMD_W-1:0]           cmd_word,
	output logic                                cmd_valid,
	output logic                                bad_frame,
	output logic                                wr_input,
	output logic                                wr_offset,
	output logic                                wr_gain,
	output logic                                wr_sfr,
	output logic [3:0]                          rd_channel,
	output logic [1:0]                          rd_target,
	output logic [hsi_pkg::BYTE_W-1:0]          tw_byte,
	output logic                                tw_byte_valid
);
	// ************************************************************
	// Pin synchronisers and strap capture
	// ************************************************************
	logic [hsi_pkg::SYNC_W-1:0] sync_d;
	logic [hsi_pkg::SYNC_W-1:0] sync_q;
	logic                       frame_q;
	logic                       done_q;
	logic                       cons_q;
	logic                       scl_q;
	logic                       sda_q;
	logic                       sel_q;
	logic                       chain_q;
	logic                       ad_hi_q;
	logic                       ad_lo_q;
	logic                       done_l_r;
	logic                       cons_tgl_r;

	assign sync_d = {frame_strobe_n, done_l_r, cons_tgl_r, scl_in, sda_in,
			if_select_pin, chain_enable_pin, addr_strap_hi, addr_strap_lo};

	// Rate far above a 400 kHz bus clock, so every edge is seen
	hsi_sync #(
		.W (hsi_pkg::SYNC_W)
	) u_sync (
		.clk (clk),
		.ce  (ce),
		.d   (sync_d),
		.q   (sync_q)
	);

	assign {frame_q, done_q, cons_q, scl_q, sda_q, sel_q, chain_q, ad_hi_q, ad_lo_q} = sync_q;

	logic       straps_taken_r;
	logic       if_spi_r;
	logic       chain_r;
	logic [1:0] ad_r;

	// Select and address straps are caught once after reset release, never under reset; chain enable is followed after that
	always_ff @(posedge clk) begin
		if (rst) begin
			straps_taken_r <= 1'b0;
			if_spi_r       <= 1'b0;
			chain_r        <= 1'b0;
			ad_r           <= 2'h0;
		end else if (ce && !straps_taken_r) begin
			straps_taken_r <= 1'b1;
			if_spi_r       <= sel_q;
			ad_r           <= {ad_hi_q, ad_lo_q};
		end else if (ce) begin
			chain_r        <= chain_q;
		end
	end

	logic spi_on;
	logic tw_on;
	assign spi_on = straps_taken_r && if_spi_r;
	assign tw_on  = straps_taken_r && !if_spi_r;

	// ************************************************************
	// Link domain: shifting on the serial clock
	// ************************************************************
	// Mode and readback words are quasi-static here: they only change
	// between frames, while the serial clock stands still.
	logic [hsi_pkg::CNT_W-1:0] bit_cnt_r;
	logic [hsi_pkg::CMD_W-1:0] shift_r;
	logic [hsi_pkg::CMD_W-1:0] rb_frame_r;
	logic                      rb_req_tgl_r;
	logic                      armed_link;
	logic                      started_r;
	logic                      out_r;
	logic                      shift_en;

	assign armed_link = rb_req_tgl_r != cons_tgl_r;
	assign shift_en   = spi_on && (chain_r || bit_cnt_r != hsi_pkg::CNT_FULL);

	// Strobe high holds the counter clear, so its fall restarts the count
	always_ff @(negedge spi_sclk or posedge frame_strobe_n) begin
		if (frame_strobe_n) begin
			bit_cnt_r <= hsi_pkg::CNT_ZERO;
		end else if (spi_on && bit_cnt_r != hsi_pkg::CNT_FULL) begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	always_ff @(negedge spi_sclk or posedge rst) begin
		if (rst) begin
			done_l_r   <= 1'b0;
			cons_tgl_r <= 1'b0;
		end else if (!frame_strobe_n && spi_on) begin
			done_l_r <= (bit_cnt_r == hsi_pkg::CNT_LAST) ||
					(done_l_r && bit_cnt_r != hsi_pkg::CNT_ZERO);
			if (bit_cnt_r == hsi_pkg::CNT_ZERO && armed_link) begin
				cons_tgl_r <= ~cons_tgl_r;
			end
		end
	end

	// Data is taken on the falling clock edge
	always_ff @(negedge spi_sclk) begin
		if (!frame_strobe_n && shift_en) begin
			if (bit_cnt_r == hsi_pkg::CNT_ZERO && armed_link) begin
				shift_r <= {rb_frame_r[hsi_pkg::CMD_W-2:0], serial_in};
			end else begin
				shift_r <= {shift_r[hsi_pkg::CMD_W-2:0], serial_in};
			end
		end
	end

	always_ff @(posedge spi_sclk or posedge frame_strobe_n) begin
		if (frame_strobe_n) begin
			started_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
		end
	end

	always_ff @(posedge spi_sclk) begin
		out_r <= shift_r[hsi_pkg::CMD_W-1];
	end

	// Before the first rising edge the leading bit is already presented
	assign serial_out = started_r ? out_r :
			(armed_link ? rb_frame_r[hsi_pkg::CMD_W-1] : shift_r[hsi_pkg::CMD_W-1]);

	// ************************************************************
	// Frame end: latch, decode, readback set-up
	// ************************************************************
	logic       frame_prev_r;
	logic       frame_rise;
	logic [3:0] cmd_ch;
	logic [1:0] cmd_tgt;
	logic       cmd_rd;
	logic       is_nop;

	assign frame_rise = frame_q && !frame_prev_r;
	assign cmd_ch     = shift_r[hsi_pkg::CH_HI:hsi_pkg::CH_LO] & CH_MASK;
	assign cmd_tgt    = shift_r[hsi_pkg::TGT_HI:hsi_pkg::TGT_LO];
	assign cmd_rd     = shift_r[hsi_pkg::RW_BIT];
	assign is_nop     = cmd_tgt == hsi_pkg::TGT_SFR && cmd_ch == hsi_pkg::CH_NOP;

	logic cmd_valid_r;
	logic bad_frame_r;
	logic wr_input_r;
	logic wr_offset_r;
	logic wr_gain_r;
	logic wr_sfr_r;
	logic rb_load_r;
	logic [hsi_pkg::CMD_W-1:0] cmd_word_r;
	logic [3:0] rd_channel_r;
	logic [1:0] rd_target_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			frame_prev_r <= 1'b1;
		end else if (ce) begin
			frame_prev_r <= frame_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_valid_r  <= 1'b0;
			bad_frame_r  <= 1'b0;
			wr_input_r   <= 1'b0;
			wr_offset_r  <= 1'b0;
			wr_gain_r    <= 1'b0;
			wr_sfr_r     <= 1'b0;
			rb_load_r    <= 1'b0;
			cmd_word_r   <= '0;
			rd_channel_r <= 4'h0;
			rd_target_r  <= 2'h0;
		end else if (ce) begin
			cmd_valid_r <= 1'b0;
			bad_frame_r <= 1'b0;
			wr_input_r  <= 1'b0;
			wr_offset_r <= 1'b0;
			wr_gain_r   <= 1'b0;
			wr_sfr_r    <= 1'b0;
			rb_load_r   <= 1'b0;
			if (spi_on && frame_rise) begin
				if (!done_q) begin
					bad_frame_r <= 1'b1;
				end else begin
					cmd_word_r  <= {shift_r[hsi_pkg::CMD_W-1:hsi_pkg::CH_HI+1], cmd_ch,
							shift_r[hsi_pkg::TGT_HI:0]};
					cmd_valid_r <= 1'b1;
					if (cmd_rd) begin
						rd_channel_r <= cmd_ch;
						rd_target_r  <= cmd_tgt;
						rb_load_r    <= 1'b1;
					end else begin
						wr_input_r  <= cmd_tgt == hsi_pkg::TGT_INPUT;
						wr_offset_r <= cmd_tgt == hsi_pkg::TGT_OFFSET;
						wr_gain_r   <= cmd_tgt == hsi_pkg::TGT_GAIN;
						wr_sfr_r    <= cmd_tgt == hsi_pkg::TGT_SFR && !is_nop;
					end
				end
			end
		end
	end

	// ************************************************************
	// Readback handshake toward the link domain
	// ************************************************************
	// The request toggle flips only when no readback is pending, so a
	// new request and a consumption in the same cycle never cancel.
	logic armed_clk;
	assign armed_clk = rb_req_tgl_r != cons_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			rb_req_tgl_r <= 1'b0;
			rb_frame_r   <= '0;
		end else if (ce && rb_load_r) begin
			rb_frame_r <= {cmd_word_r[hsi_pkg::CMD_W-1:hsi_pkg::CMD_W-hsi_pkg::HDR_W],
					readback_data};
			if (!armed_clk) begin
				rb_req_tgl_r <= ~rb_req_tgl_r;
			end
		end
	end

	assign cmd_word   = cmd_word_r;
	assign cmd_valid  = cmd_valid_r;
	assign bad_frame  = bad_frame_r;
	assign wr_input   = wr_input_r;
	assign wr_offset  = wr_offset_r;
	assign wr_gain    = wr_gain_r;
	assign wr_sfr     = wr_sfr_r;
	assign rd_channel = rd_channel_r;
	assign rd_target  = rd_target_r;

	// ************************************************************
	// Two-wire write-only slave
	// ************************************************************
	logic                       scl_p_r;
	logic                       sda_p_r;
	logic                       tw_start;
	logic                       tw_stop;
	logic                       scl_rise;
	logic                       scl_fall;
	hsi_pkg::hsi_tw_state_t     tw_state_r;
	logic [3:0]                 tw_cnt_r;
	logic [hsi_pkg::BYTE_W-1:0] tw_shift_r;
	logic                       tw_data_next_r;
	logic                       sda_oe_n_r;
	logic                       sda_out_r;
	logic [hsi_pkg::BYTE_W-1:0] tw_byte_r;
	logic                       tw_byte_valid_r;
	logic [hsi_pkg::BYTE_W-1:0] tw_match;

	assign tw_start = scl_q && scl_p_r && sda_p_r && !sda_q;
	assign tw_stop  = scl_q && scl_p_r && !sda_p_r && sda_q;
	assign scl_rise = scl_q && !scl_p_r;
	assign scl_fall = !scl_q && scl_p_r;
	assign tw_match = {hsi_pkg::TW_ADDR_HI, ad_r, 1'b0};

	always_ff @(posedge clk) begin
		if (rst) begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else if (ce) begin
			scl_p_r <= scl_q;
			sda_p_r <= sda_q;
		end
	end

	// The block only ever pulls the data line; the clock is never driven
	always_ff @(posedge clk) begin
		if (rst) begin
			tw_state_r      <= hsi_pkg::HSI_TW_IDLE;
			tw_cnt_r        <= 4'h0;
			tw_shift_r      <= '0;
			tw_data_next_r  <= 1'b0;
			sda_oe_n_r      <= 1'b1;
			sda_out_r       <= 1'b0;
			tw_byte_r       <= '0;
			tw_byte_valid_r <= 1'b0;
		end else if (ce) begin
			tw_byte_valid_r <= 1'b0;
			if (!tw_on || tw_stop) begin
				tw_state_r <= hsi_pkg::HSI_TW_IDLE;
				sda_oe_n_r <= 1'b1;
			end else if (tw_start) begin
				tw_state_r <= hsi_pkg::HSI_TW_ADDR;
				tw_cnt_r   <= 4'h0;
				sda_oe_n_r <= 1'b1;
			end else begin
				case (tw_state_r)
					hsi_pkg::HSI_TW_ADDR,
					hsi_pkg::HSI_TW_DATA: begin
						if (scl_rise && tw_cnt_r != hsi_pkg::TW_BITS) begin
							tw_shift_r <= {tw_shift_r[hsi_pkg::BYTE_W-2:0], sda_q};
							tw_cnt_r   <= tw_cnt_r + 4'h1;
						end else if (scl_fall && tw_cnt_r == hsi_pkg::TW_BITS) begin
							tw_cnt_r <= 4'h0;
							if (tw_state_r == hsi_pkg::HSI_TW_DATA) begin
								tw_byte_r       <= tw_shift_r;
								tw_byte_valid_r <= 1'b1;
								sda_oe_n_r      <= 1'b0;
								tw_state_r      <= hsi_pkg::HSI_TW_ACK;
							end else if (tw_shift_r == tw_match) begin
								sda_oe_n_r <= 1'b0;
								tw_state_r <= hsi_pkg::HSI_TW_ACK;
							end else begin
								tw_state_r <= hsi_pkg::HSI_TW_SKIP;
							end
						end
					end
					hsi_pkg::HSI_TW_ACK: begin
						if (scl_fall) begin
							sda_oe_n_r <= 1'b1;
							tw_state_r <= hsi_pkg::HSI_TW_DATA;
						end
					end
					hsi_pkg::HSI_TW_SKIP,
					hsi_pkg::HSI_TW_IDLE: begin
						sda_oe_n_r <= 1'b1;
					end
					default: begin
						tw_state_r <= hsi_pkg::HSI_TW_IDLE;
						sda_oe_n_r <= 1'b1;
					end
				endcase
			end
		end
	end

	assign sda_out       = sda_out_r;
	assign sda_oe_n      = sda_oe_n_r;
	assign tw_byte       = tw_byte_r;
	assign tw_byte_valid = tw_byte_valid_r;
endmodule : hsi_top
`default_nettype wire

/* hdl/hsi_pkg.sv */
// Constants and types shared by the serial host interface
// What this block does
// - Strap high selects the three/four-wire synchronous serial port.
// - Strap low makes the block a two-wire slave that never drives the clock.
// - Command is 24 bits MSB first: bank, read, zeros, channel, target, payload.
// - Target 11 input data, 10 offset, 01 gain, 00 special functions.
// - Chain enable low: standalone, one 24-bit command per frame.
// - Chain enable high: daisy chain, shifted-through bits leave on serial_out.
// - Falling frame strobe starts a frame and clears the clock counter.
// - Standalone: only falling strobe matters until 24 bits; then clock ignored.
// - Daisy chain: every clock shifts while strobe low; extra bits ripple out.
// - serial_out changes on rising clock; receiver samples on falling clock.
// - Strobe rising after a full transfer latches the command, stops shifting.
// - Strobe rising before 24 clocks is a bad frame and is discarded. Code: a frame with no clocks after a good frame latches the old command again.
// - Read bit set selects a register by channel and target; payload ignored.
// - Next frame shifts the selected register out on serial_out.
// - Target 00 with channel 0000 is a no-operation that still clocks readback.
// - Readback frame: payload holds register, upper 10 bits repeat the address.
// - With clock idling high, first readback bit appears at strobe fall.
// - Two-wire address is 10101 plus the two address strap pins.
// - Two-wire slave works at bus clocks up to 400 kHz.
// - Matching address or data byte is acknowledged low in the ninth clock.
package hsi_pkg;
	localparam int          CMD_W      = 24;
	localparam int          CNT_W      = 5;
	localparam logic [4:0]  CNT_FULL   = 5'h18;
	localparam logic [4:0]  CNT_LAST   = 5'h17;
	localparam logic [4:0]  CNT_ZERO   = 5'h00;
	localparam int          BANK_BIT   = 23;
	localparam int          RW_BIT     = 22;
	localparam int          CH_HI      = 19;
	localparam int          CH_LO      = 16;
	localparam int          TGT_HI     = 15;
	localparam int          TGT_LO     = 14;
	localparam int          PAY_W      = 14;
	localparam int          HDR_W      = 10;
	localparam logic [1:0]  TGT_INPUT  = 2'h3;
	localparam logic [1:0]  TGT_OFFSET = 2'h2;
	localparam logic [1:0]  TGT_GAIN   = 2'h1;
	localparam logic [1:0]  TGT_SFR    = 2'h0;
	localparam logic [3:0]  CH_NOP     = 4'h0;
	localparam logic [4:0]  TW_ADDR_HI = 5'h15;
	localparam int          BYTE_W     = 8;
	localparam logic [3:0]  TW_BITS    = 4'h8;
	localparam int          SYNC_W     = 9;

	typedef enum logic [2:0] {
		HSI_TW_IDLE,
		HSI_TW_ADDR,
		HSI_TW_DATA,
		HSI_TW_ACK,
		HSI_TW_SKIP
	} hsi_tw_state_t;
endpackage : hsi_pkg

/* hdl/hsi_sync.sv */
// Two flip-flop level synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module hsi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (ce) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : hsi_sync
`default_nettype wire

/* dv/hsi_top_monitor.sv */
// Concurrent checks on the serial host interface ports
`timescale 1ns/100ps
`default_nettype none
module hsi_top_monitor (
	input wire logic                      clk,
	input wire logic                      rst,
	input wire logic                      if_select_pin,
	input wire logic                      frame_strobe_n,
	input wire logic                      sda_out,
	input wire logic                      sda_oe_n,
	input wire logic [hsi_pkg::CMD_W-1:0] cmd_word,
	input wire logic                      cmd_valid,
	input wire logic                      bad_frame,
	input wire logic                      wr_input,
	input wire logic                      wr_offset,
	input wire logic                      wr_gain,
	input wire logic                      wr_sfr,
	input wire logic                      tw_byte_valid
);
	// ************************************************
	// Assertions
	// ************************************************
	default clocking mon_cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_MODE_SERIAL: assert property (cmd_valid |-> if_select_pin)
		else $error("command latched while two-wire mode selected");
	AST_MODE_TW: assert property ((tw_byte_valid || !sda_oe_n) |-> !if_select_pin)
		else $error("two-wire activity while serial port selected");
	AST_SDA_LOW: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	AST_WR_CAUSE: assert property ((wr_input || wr_offset || wr_gain || wr_sfr) |->
		cmd_valid && !cmd_word[22] && $onehot({wr_input, wr_offset, wr_gain, wr_sfr}))
		else $error("write strobe without a latched write command");
	AST_DECODE: assert property (cmd_valid && !cmd_word[22] |->
		wr_input == (cmd_word[15:14] == 2'h3) && wr_offset == (cmd_word[15:14] == 2'h2)
		&& wr_gain == (cmd_word[15:14] == 2'h1)
		&& wr_sfr == (cmd_word[15:14] == 2'h0 && cmd_word[19:16] != 4'h0))
		else $error("target decode mismatch");
	AST_PULSES: assert property ((cmd_valid || bad_frame) |=> !cmd_valid && !bad_frame)
		else $error("frame result pulse longer than one cycle");
	AST_BAD_DISCARD: assert property (bad_frame |-> !cmd_valid && $stable(cmd_word))
		else $error("bad frame changed the command");
	AST_HOLD: assert property (!cmd_valid |-> $stable(cmd_word))
		else $error("command word changed without a good frame");
	AST_AFTER_STROBE: assert property (cmd_valid |-> frame_strobe_n && $past(frame_strobe_n, 2))
		else $error("command latched while strobe low");
	AST_BAD_STROBE: assert property (bad_frame |-> frame_strobe_n)
		else $error("bad frame flagged while strobe low");
endmodule : hsi_top_monitor
bind hsi_top hsi_top_monitor hsi_top_monitor_inst (.clk(clk), .rst(rst),
	.if_select_pin(if_select_pin), .frame_strobe_n(frame_strobe_n), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .cmd_word(cmd_word), .cmd_valid(cmd_valid), .bad_frame(bad_frame),
	.wr_input(wr_input), .wr_offset(wr_offset), .wr_gain(wr_gain), .wr_sfr(wr_sfr),
	.tw_byte_valid(tw_byte_valid));
`default_nettype wire

/* dv/hsi_host_model.sv */
// Host controller model: serial port master and two-wire write master
`timescale 1ns/100ps
`default_nettype none
module hsi_host_model (
	output var logic  frame_strobe_n,
	output var logic  spi_sclk,
	output var logic  serial_in,
	input  wire logic serial_out,
	output var logic  scl,
	output var logic  sda_drv,
	input  wire logic sda
);
	// ************************************************
	// Serial port master
	// ************************************************
	localparam realtime HALF = 7.5;
	localparam realtime QTR  = 625.0;
	initial begin
		frame_strobe_n = 1'b1;
		spi_sclk = 1'b1;
		serial_in = 1'b0;
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Clock idles high and stands still between frames
	task automatic frame(input logic [47:0] bits, input int n, output logic [47:0] rx);
		rx = 48'h0;
		frame_strobe_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in = bits[47-i];
			#HALF spi_sclk = 1'b0;
			rx = {rx[46:0], serial_out};
			#HALF spi_sclk = 1'b1;
		end
		#HALF frame_strobe_n = 1'b1;
		serial_in = ~serial_in;
	endtask : frame
	// ************************************************
	// Two-wire master, 400 kHz bit rate
	// ************************************************
	task automatic tw_start();
		sda_drv = 1'b0;
		#QTR scl = 1'b0;
		#QTR;
	endtask : tw_start
	task automatic tw_send(input logic [7:0] b, output logic ack);
		ack = 1'b0;
		for (int i = 0; i < 9; i++) begin
			sda_drv = (i < 8) ? b[7-i] : 1'b1;
			#QTR scl = 1'b1;
			ack = ~sda;
			#(2*QTR) scl = 1'b0;
			#QTR;
		end
	endtask : tw_send
	task automatic tw_stop();
		sda_drv = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_drv = 1'b1;
		#QTR;
	endtask : tw_stop
endmodule : hsi_host_model
`default_nettype wire

/* dv/hsi_top_test.sv */
// Self-checking testbench for the serial host interface
`timescale 1ns/100ps
`default_nettype none
module hsi_top_test;
	// ************************************************
	// Signals and instances
	// ************************************************
	typedef struct packed {
		logic [23:0] w;
		logic [3:0]  wr;
	} hsi_row_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        if_sel = 1'b1;
	logic        chain = 1'b0;
	logic        strap_hi = 1'b1;
	logic        strap_lo = 1'b0;
	logic [13:0] rb_data = 14'h2A5C;
	logic        frame_strobe_n, spi_sclk, serial_in, serial_out, scl, sda_drv;
	logic        sda_out, sda_oe_n, cmd_valid, bad_frame, tw_byte_valid;
	logic        wr_input, wr_offset, wr_gain, wr_sfr, ack;
	logic [23:0] cmd_word;
	logic [3:0]  rd_channel, wrs;
	logic [1:0]  rd_target;
	logic [7:0]  tw_byte;
	logic [47:0] rx;
	int          n_fail = 0;
	int          check_count = 0;
	int          n_cmd = 0;
	int          n_bad = 0;
	int          n_tw = 0;
	wire         sda_line = sda_drv & (sda_oe_n | sda_out);
	// Bank bit set only on the gain row, as toggle mode would send
	hsi_row_t rows [6] = '{'{24'h05D234, 4'h8}, '{24'h0F8ABC, 4'h4}, '{24'h807FFE, 4'h2},
		'{24'h0C0155, 4'h1}, '{24'h000000, 4'h0}, '{24'h404000, 4'h0}};
	always #2.5 clk = ~clk;
	hsi_top hsi_top_inst (.clk(clk), .rst(rst), .ce(1'b1), .if_select_pin(if_sel),
		.chain_enable_pin(chain), .addr_strap_hi(strap_hi), .addr_strap_lo(strap_lo),
		.frame_strobe_n(frame_strobe_n), .spi_sclk(spi_sclk), .serial_in(serial_in),
		.serial_out(serial_out), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .readback_data(rb_data), .cmd_word(cmd_word),
		.cmd_valid(cmd_valid), .bad_frame(bad_frame), .wr_input(wr_input),
		.wr_offset(wr_offset), .wr_gain(wr_gain), .wr_sfr(wr_sfr), .rd_channel(rd_channel),
		.rd_target(rd_target), .tw_byte(tw_byte), .tw_byte_valid(tw_byte_valid));
	hsi_host_model hsi_host_model_inst (.frame_strobe_n(frame_strobe_n), .spi_sclk(spi_sclk),
		.serial_in(serial_in), .serial_out(serial_out), .scl(scl), .sda_drv(sda_drv),
		.sda(sda_line));
	// Pulse outputs stand one cycle, so they are counted here
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			wrs = {wr_input, wr_offset, wr_gain, wr_sfr};
		end
		if (bad_frame === 1'b1) n_bad++;
		if (tw_byte_valid === 1'b1) n_tw++;
	end
	// ************************************************
	// Helpers
	// ************************************************
	task check(input logic [47:0] seen, input logic [47:0] exp);
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			n_fail++;
		end
		check_count++;
	endtask : check
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	// Result pulses land on the third clock edge after strobe rise; 10 also covers the inter-frame gap
	task gap;
		repeat (10) @(posedge clk);
		#1;
	endtask : gap
	task frm(input logic [47:0] bits, input int n);
		hsi_host_model_inst.frame(bits, n, rx);
		gap;
	endtask : frm
	task do_reset;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
	endtask : do_reset
	initial begin
		#400000;
		n_fail++;
		finish_test;
	end
	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		do_reset;
		check(cmd_word, 24'h0);
		check(sda_oe_n, 1'b1);
		gap;
		foreach (rows[i]) begin
			frm({rows[i].w, 24'h0}, 24);
			check(n_cmd, i + 1);
			check(cmd_word, rows[i].w);
			check(wrs, rows[i].wr);
		end
		check({rd_channel, rd_target}, 6'h01);
		frm({24'h4B8ABC, 24'h0}, 24);
		check({rd_channel, rd_target}, {4'hB, 2'h2});
		frm(48'h0, 24);
		check(rx[23:0], {10'h12E, 14'h2A5C});
		check(n_cmd, 8);
		frm({24'h05C777, 24'h0}, 23);
		check(n_bad, 32'd1);
		check(n_cmd, 32'd8);
		check(cmd_word, 24'h0);
		frm({24'h05C001, 24'hFFFFFF}, 30);
		check(cmd_word, 24'h05C001);
		chain = 1'b1;
		gap;
		frm({24'h0FC111, 24'h01C222}, 48);
		check(cmd_word, 24'h01C222);
		check(rx[23:0], 24'h0FC111);
		chain = 1'b0;
		if_sel = 1'b0;
		do_reset;
		gap;
		hsi_host_model_inst.tw_start();
		hsi_host_model_inst.tw_send(8'hAC, ack);
		check(ack, 1'b1);
		hsi_host_model_inst.tw_send(8'h5A, ack);
		check(ack, 1'b1);
		hsi_host_model_inst.tw_stop();
		gap;
		check({tw_byte, n_tw}, {8'h5A, 32'd1});
		// Wrong strap address, then read direction: both must go unanswered
		foreach (rows[i]) if (i < 2) begin
			hsi_host_model_inst.tw_start();
			hsi_host_model_inst.tw_send(i == 0 ? 8'hAE : 8'hAD, ack);
			check(ack, 1'b0);
			hsi_host_model_inst.tw_stop();
		end
		frm({24'h05C123, 24'h0}, 24);
		// Command count carries over the reset; serial pins must add none
		check(n_cmd, 32'd10);
		check({n_tw, sda_oe_n}, {32'd1, 1'b1});
		finish_test;
	end
endmodule : hsi_top_test
`default_nettype wire
